// >>> verilog/lead_off_pkg.sv
`default_nettype none
package lead_off_pkg;

  // Register addresses seen by the serial register read command.
  localparam logic [5:0] ADDR_W_LSB           = 6'h00;
  localparam logic [5:0] ELECTRODE_CONN_ADDR  = 6'h1d;
  localparam logic [5:0] DC_RANGE_ADDR        = 6'h1e;
  localparam logic [5:0] OP_STATE_ADDR        = 6'h1f;

  // Register word width and values after reset.
  localparam int          REG_W               = 24;
  localparam logic [23:0] ELECTRODE_CONN_RST  = 24'h000000;
  localparam logic [23:0] DC_RANGE_RST        = 24'h000000;
  localparam logic [23:0] OP_STATE_RST        = 24'h000000;
  localparam logic [23:0] UNMAPPED_READ       = 24'h000000;

  // Electrode counts: six limb and chest electrodes plus common electrode.
  localparam int NUM_ELEC    = 6;
  localparam int NUM_DC      = 7;
  localparam int NUM_ADC     = 5;
  localparam int CE_IDX      = 6;
  localparam int RLD_IDX     = 0;
  localparam int ACC_W       = NUM_DC + NUM_ADC;

  // Field positions in the electrode connection register.
  localparam int CONN_TOP_POS   = 23;
  localparam int CONN_CE_POS    = 13;
  localparam int ADC_TOP_POS    = 12;

  // Field positions in the dc comparator range register.
  localparam int OVER_TOP_POS   = 23;
  localparam int OVER_CE_POS    = 13;
  localparam int UNDER_TOP_POS  = 12;
  localparam int UNDER_CE_POS   = 2;

  // Synchroniser depth for comparator pins.
  localparam int SYNC_STAGES    = 2;

endpackage
`default_nettype wire

// >>> verilog/flag_acc_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries per-frame flag accumulation between the top and its accumulator.
interface flag_acc_if #(parameter int W = 12);
  logic [W-1:0] set;
  logic         clear;
  logic [W-1:0] flags;
  modport acc  (input set, input clear, output flags);
  modport user (output set, output clear, input flags);
endinterface : flag_acc_if
`default_nettype wire

// >>> verilog/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import lead_off_pkg::*;
#(
  parameter int W = 7
) (
  input  wire logic         clock,   // System clock.
  input  wire logic         sys_rst, // Asynchronous reset, active high.
  input  wire logic [W-1:0] pin_in,  // Asynchronous comparator levels.
  output logic      [W-1:0] sync_out // Levels safe for clocked logic.
);

  logic [W-1:0] meta_r;

  // Two stages per bit; only the second stage is read by other logic.
  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          meta_r[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_r[i]   <= pin_in[i];
          sync_out[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule // pin_sync
`default_nettype wire

// >>> verilog/frame_flag_acc.sv
`timescale 1ns/1ps
`default_nettype none
module frame_flag_acc #(
  parameter int W = 12
) (
  input  wire logic clock,   // System clock.
  input  wire logic sys_rst, // Asynchronous reset, active high.
  flag_acc_if.acc   bus      // Set, frame clear and accumulated flags.
);

  // Each flag is sticky within a frame; a set landing on the clear cycle
  // is carried into the next frame instead of being dropped.
  generate
    for (genvar i = 0; i < W; i++) begin : g_flag
      logic flag_nxt;
      always_comb begin
        if (bus.clear) begin
          flag_nxt = bus.set[i]; // R16
        end else begin
          flag_nxt = bus.flags[i] | bus.set[i];
        end
      end
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          bus.flags[i] <= 1'b0;
        end else begin
          bus.flags[i] <= flag_nxt;
        end
      end
    end
  endgenerate

endmodule // frame_flag_acc
`default_nettype wire

// >>> verilog/electrode_lead_off_status.sv
// Contract
// R01 - Connection flags: right leg drive bit 23 down to V2 bit 18, common bit 13.
// R02 - With one lead-off method enabled, flags report that method's result.
// R03 - With dc and ac both enabled, flags carry only the ac result; right leg drive and common flags keep the dc result.
// R04 - Common electrode flag is driven by dc detection only.
// R05 - Flag reads 1 when disconnected, 0 when connected.
// R06 - Right leg drive flag is never updated by ac detection.
// R07 - Connection flags stick within a frame, clear on frame transfer.
// R08 - ADC out-of-range flags at bits 12 down to 8, left arm first.
// R09 - ADC range flags accumulate per frame and clear on frame transfer.
// R10 - Connection register bits 17:14 and 7:0 read as zero.
// R11 - Overrange flags bits 23 to 18 and 13, set above 2.4 V.
// R12 - Underrange flags bits 12 to 7 and 2, set below 0.2 V.
// R13 - Comparator register bits 17:14, 6:3 and 1:0 read zero.
// R14 - Comparator register is left out of the frame stream.
// R15 - Comparator register at 0x1E, state register at 0x1F, zero after reset.
// R16 - A detection on the clearing cycle is kept for the next frame.
`timescale 1ns/1ps
`default_nettype none
module electrode_lead_off_status
  import lead_off_pkg::*;
(
  input  wire logic              clock,          // 25 MHz system clock.
  input  wire logic              sys_rst,        // Async reset, active high.
  input  wire logic [NUM_DC-1:0] dc_over_pin,    // Comparator above 2.4 V.
  input  wire logic [NUM_DC-1:0] dc_under_pin,   // Comparator below 0.2 V.
  input  wire logic [NUM_ADC-1:0] ac_off_pin,    // Ac amplitude says off.
  input  wire logic [NUM_ADC-1:0] adc_range_err, // Conversion out of range.
  input  wire logic              dc_lo_enable,   // Dc lead-off enabled.
  input  wire logic              ac_lo_enable,   // Ac lead-off enabled.
  input  wire logic              frame_load,     // Frame moved to serial buf.
  input  wire logic              rd_req,         // Register read command.
  input  wire logic [5:0]        rd_addr,        // Register read address.
  output logic      [REG_W-1:0]  rd_data,        // Read result, held.
  output logic                   rd_valid,       // Read result strobe.
  output logic      [REG_W-1:0]  frame_word,     // Status word for frame.
  output logic                   frame_valid     // Frame word strobe.
);

  // Synchronised comparator levels.
  logic [NUM_DC-1:0]  dc_over_s;
  logic [NUM_DC-1:0]  dc_under_s;
  logic [NUM_ADC-1:0] ac_off_s;

  // Per-electrode detection results feeding the accumulator.
  logic [NUM_DC-1:0]  dc_off;
  logic [NUM_DC-1:0]  conn_set;
  logic [REG_W-1:0]   conn_word;
  logic [REG_W-1:0]   dc_word;

  // Registers visible to the host.
  logic [REG_W-1:0]   conn_snap_r;
  logic [REG_W-1:0]   dc_range_r;
  logic [REG_W-1:0]   op_state_r;
  logic [REG_W-1:0]   rd_data_nxt;

  flag_acc_if #(.W(ACC_W)) acc_bus ();

  // The comparators are analog and free running, so every level crosses
  // two flip-flops before any decision is made from it.
  pin_sync #(.W(NUM_DC)) u_sync_over (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .pin_in   (dc_over_pin),
    .sync_out (dc_over_s)
  );

  pin_sync #(.W(NUM_DC)) u_sync_under (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .pin_in   (dc_under_pin),
    .sync_out (dc_under_s)
  );

  pin_sync #(.W(NUM_ADC)) u_sync_ac (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .pin_in   (ac_off_pin),
    .sync_out (ac_off_s)
  );

  // An electrode fails dc lead-off when it leaves the window either way.
  assign dc_off = dc_over_s | dc_under_s;

  // Method selection per electrode. Ac has no sense path on the right leg
  // drive or on the common electrode, so those two follow dc alone and
  // stay quiet when only ac is enabled.
  generate
    for (genvar e = 0; e < NUM_DC; e++) begin : g_sel
      if (e == RLD_IDX) begin : g_rld
        assign conn_set[e] = dc_lo_enable & dc_off[e]; // R06
      end else if (e == CE_IDX) begin : g_ce
        assign conn_set[e] = dc_lo_enable & dc_off[e]; // R04
      end else begin : g_ac
        // Ac wins when both are on; dc result then lives only in the
        // comparator register.
        assign conn_set[e] = ac_lo_enable ? ac_off_s[e - 1] // R03
                                          : (dc_lo_enable & dc_off[e]); // R02
      end
    end
  endgenerate

  // A high bit means disconnected, matching the comparator sense.
  assign acc_bus.set   = {adc_range_err, conn_set}; // R05 R09
  assign acc_bus.clear = frame_load; // R07 R09

  // Accumulates connection and conversion flags across one frame.
  frame_flag_acc #(.W(ACC_W)) u_acc (
    .clock   (clock),
    .sys_rst (sys_rst),
    .bus     (acc_bus)
  );

  // Place accumulated flags in the connection register layout; every bit
  // not assigned below, the reserved fields, stays at zero.
  always_comb begin
    conn_word = ELECTRODE_CONN_RST; // R10
    for (int e = 0; e < NUM_ELEC; e++) begin
      conn_word[CONN_TOP_POS - e] = acc_bus.flags[e]; // R01
    end
    conn_word[CONN_CE_POS] = acc_bus.flags[CE_IDX]; // R01
    for (int a = 0; a < NUM_ADC; a++) begin
      conn_word[ADC_TOP_POS - a] = acc_bus.flags[NUM_DC + a]; // R08
    end
  end

  // Live comparator layout: overrange high half, underrange low half.
  always_comb begin
    dc_word = DC_RANGE_RST; // R13
    for (int e = 0; e < NUM_ELEC; e++) begin
      dc_word[OVER_TOP_POS - e]  = dc_over_s[e]; // R11
      dc_word[UNDER_TOP_POS - e] = dc_under_s[e]; // R12
    end
    dc_word[OVER_CE_POS]  = dc_over_s[CE_IDX]; // R11
    dc_word[UNDER_CE_POS] = dc_under_s[CE_IDX]; // R12
  end

  // Snapshot the accumulated word when the frame is handed to the serial
  // buffer, so the host reads a stable picture of the finished frame.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      conn_snap_r <= ELECTRODE_CONN_RST;
    end else if (frame_load) begin
      conn_snap_r <= conn_word; // R07
    end
  end

  // Comparator register tracks the synchronised levels every cycle.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dc_range_r <= DC_RANGE_RST; // R15
    end else begin
      dc_range_r <= dc_word; // R11 R12
    end
  end

  // Operating state fields are owned elsewhere; this block holds the
  // word at its reset value so a read of the address is well defined.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      op_state_r <= OP_STATE_RST; // R15
    end else begin
      op_state_r <= OP_STATE_RST;
    end
  end

  // Frame stream carries only the connection word; the comparator word
  // must be fetched by an explicit read.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      frame_word  <= ELECTRODE_CONN_RST;
      frame_valid <= 1'b0;
    end else begin
      frame_valid <= frame_load;
      if (frame_load) begin
        frame_word <= conn_word; // R14
      end
    end
  end

  // Read address decode; unmapped addresses answer zero.
  always_comb begin
    if (rd_addr == ELECTRODE_CONN_ADDR) begin
      rd_data_nxt = conn_snap_r;
    end else if (rd_addr == DC_RANGE_ADDR) begin
      rd_data_nxt = dc_range_r; // R14 R15
    end else if (rd_addr == OP_STATE_ADDR) begin
      rd_data_nxt = op_state_r; // R15
    end else begin
      rd_data_nxt = UNMAPPED_READ;
    end
  end

  // Read answer one cycle after the command; data holds until next read.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data  <= UNMAPPED_READ;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_req;
      if (rd_req) begin
        rd_data <= rd_data_nxt;
      end
    end
  end

endmodule // electrode_lead_off_status
`default_nettype wire

// >>> tb/electrode_lead_off_status_chk.sv
`timescale 1ns/1ps
`default_nettype none
module electrode_lead_off_status_chk
  import lead_off_pkg::*;
(
  input wire logic [0:0]  clock,        // Clock.
  input wire logic        sys_rst,      // Reset.
  input wire logic [6:0]  dc_over_pin,  // Over pins.
  input wire logic [6:0]  dc_under_pin, // Under pins.
  input wire logic        frame_load,   // Frame pulse.
  input wire logic        rd_req,       // Read pulse.
  input wire logic [5:0]  rd_addr,      // Read address.
  input wire logic [23:0] rd_data,      // Read data.
  input wire logic        rd_valid,     // Read strobe.
  input wire logic [23:0] frame_word,   // Frame word.
  input wire logic        frame_valid   // Frame strobe.
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Strobes answer exactly one cycle after their request, never otherwise.
  property p_rd_ans; rd_req |=> rd_valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  property p_rd_one; !rd_req |=> !rd_valid; endproperty
  a_rd_one: assert property (p_rd_one) else $error("stray read");
  property p_fr_ans; frame_load |=> frame_valid; endproperty
  a_fr_ans: assert property (p_fr_ans) else $error("frame missing");
  property p_fr_one; !frame_load |=> !frame_valid && $stable(frame_word);
  endproperty
  a_fr_one: assert property (p_fr_one) else $error("frame moved");

  // Register contents seen through the frame and read paths.
  property p_rsv; frame_valid |-> frame_word[17:14] == 4'h0 &&
    frame_word[7:0] == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_snap; rd_req && !frame_load && rd_addr == ELECTRODE_CONN_ADDR
    |=> rd_data == frame_word; endproperty
  a_snap: assert property (p_snap) else $error("snapshot differs");
  property p_opst; rd_req && rd_addr == OP_STATE_ADDR |=>
    rd_data == 24'h000000; endproperty
  a_opst: assert property (p_opst) else $error("state not zero");
  property p_dcrsv; rd_req && rd_addr == DC_RANGE_ADDR |=> rd_data[17:14]
    == 4'h0 && rd_data[6:3] == 4'h0 && rd_data[1:0] == 2'h0; endproperty
  a_dcrsv: assert property (p_dcrsv) else $error("dc reserved");

  // Pins held for three edges must show in the comparator word.
  property p_over; $stable(dc_over_pin)[*3] ##0 rd_req &&
    rd_addr == DC_RANGE_ADDR |=> rd_data[23] == $past(dc_over_pin[0]) &&
    rd_data[13] == $past(dc_over_pin[6]); endproperty
  a_over: assert property (p_over) else $error("over flag");
  property p_under; $stable(dc_under_pin)[*3] ##0 rd_req &&
    rd_addr == DC_RANGE_ADDR |=> rd_data[12] == $past(dc_under_pin[0]) &&
    rd_data[2] == $past(dc_under_pin[6]); endproperty
  a_under: assert property (p_under) else $error("under flag");
endmodule // electrode_lead_off_status_chk

bind electrode_lead_off_status electrode_lead_off_status_chk u_chk (
  .clock(clock), .sys_rst(sys_rst), .dc_over_pin(dc_over_pin),
  .dc_under_pin(dc_under_pin), .frame_load(frame_load), .rd_req(rd_req),
  .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
  .frame_word(frame_word), .frame_valid(frame_valid));
`default_nettype wire

// >>> tb/status_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module status_host_model (
  input  wire logic       clock,     // System clock.
  output logic            rd_req,    // Read command.
  output logic      [5:0] rd_addr,   // Read address.
  output logic            frame_load // Frame transfer.
);
  // Idle until the bench asks for traffic.
  initial begin
    rd_req = 1'b0;
    rd_addr = 6'h2a;
    frame_load = 1'b0;
  end

  // A read is the only way to reach the comparator word; the address is
  // scrambled afterwards so that a late sample cannot look right.
  task automatic read(input logic [5:0] addr);
    rd_req = 1'b1;
    rd_addr = addr;
    @(negedge clock);
    rd_req = 1'b0;
    rd_addr = ~addr;
    @(negedge clock);
  endtask

  // One frame transfer pulse, then a quiet cycle.
  task automatic load();
    frame_load = 1'b1;
    @(negedge clock);
    frame_load = 1'b0;
    @(negedge clock);
  endtask
endmodule // status_host_model
`default_nettype wire

// >>> tb/electrode_lead_off_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module electrode_lead_off_status_tb
  import lead_off_pkg::*;
;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [6:0]  dc_over, dc_under;
  logic [4:0]  ac_off, adc_err;
  logic        dc_en, ac_en, rd_req, frame_load, rd_valid, frame_valid;
  logic [5:0]  rd_addr;
  logic [23:0] rd_data, frame_word, ex;
  logic [23:0] exp_q[$];
  logic [31:0] seed = 32'ha8d0;
  int          errors = 0;
  int          checks_done = 0;

  // Free-running 25 MHz clock.
  always #20 clock = ~clock;

  electrode_lead_off_status u_electrode_lead_off_status (
    .clock(clock), .sys_rst(sys_rst), .dc_over_pin(dc_over),
    .dc_under_pin(dc_under), .ac_off_pin(ac_off), .adc_range_err(adc_err),
    .dc_lo_enable(dc_en), .ac_lo_enable(ac_en), .frame_load(frame_load),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .frame_word(frame_word), .frame_valid(frame_valid));

  status_host_model u_status_host_model (.clock(clock), .rd_req(rd_req),
    .rd_addr(rd_addr), .frame_load(frame_load));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Connection word; ac wins for limb and chest electrodes other than right leg drive when enabled.
  function automatic logic [23:0] conn();
    logic [23:0] w;
    logic [6:0]  d;
    d = dc_over | dc_under;
    w = 24'h000000;
    w[23] = dc_en & d[0];
    w[13] = dc_en & d[6];
    for (int i = 0; i < 5; i++) begin
      w[22-i] = ac_en ? ac_off[i] : dc_en & d[i+1];
      w[12-i] = adc_err[i];
    end
    return w;
  endfunction

  // Comparator word from the raw pin levels.
  function automatic logic [23:0] comp();
    logic [23:0] w;
    w = 24'h000000;
    for (int i = 0; i < 6; i++) begin
      w[23-i] = dc_over[i];
      w[12-i] = dc_under[i];
    end
    w[13] = dc_over[6];
    w[2] = dc_under[6];
    return w;
  endfunction

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    exp_q.push_back(e);
    u_status_host_model.read(a);
  endtask

  task automatic fr(input logic [23:0] e);
    exp_q.push_back(e);
    u_status_host_model.load();
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Results arrive in request order, so one queue serves both strobes.
  always @(negedge clock) begin
    if (rd_valid === 1'b1) check(rd_data, exp_q.pop_front());
    if (frame_valid === 1'b1) check(frame_word, exp_q.pop_front());
  end

  // The whole run is under a hundred cycles; this cuts a hang short at 500 cycles.
  initial begin
    #20000;
    errors++;
    results();
  end

  initial begin
    {dc_over, dc_under, ac_off, adc_err, dc_en, ac_en} = 26'h0000000;
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    rd(ELECTRODE_CONN_ADDR, 24'h000000);
    rd(DC_RANGE_ADDR, 24'h000000);
    rd(OP_STATE_ADDR, 24'h000000);
    rd(6'h00, 24'h000000);
    fr(24'h000000);
    $display("reset test done");
    // Every enable mode: pulse random flags, then show they stuck.
    for (int m = 0; m < 4; m++) begin
      {dc_en, ac_en} = m[1:0];
      seed = lfsr(seed);
      {dc_over, dc_under, ac_off, adc_err} = seed[23:0];
      repeat (4) @(negedge clock);
      rd(DC_RANGE_ADDR, comp());
      ex = conn();
      {dc_over, dc_under, ac_off, adc_err} = 24'h000000;
      repeat (4) @(negedge clock);
      fr(ex);
      rd(ELECTRODE_CONN_ADDR, ex);
      fr(24'h000000);
      $display("mode %0d test done", m);
    end
    // A range error on the clearing edge belongs to the next frame.
    adc_err = 5'h01;
    exp_q.push_back(24'h000000);
    fork
      u_status_host_model.load();
      @(negedge clock) adc_err = 5'h00;
    join
    fr(24'h001000);
    $display("clear edge test done");
    repeat (3) @(negedge clock);
    results();
  end
endmodule // electrode_lead_off_status_tb
`default_nettype wire
